// ===== smp_pkg.sv
// shared constants and types for the signal monitor peak detector
package smp_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] SYNC_CTRL_IDX     = 10'h26F;
    localparam logic [9:0] MON_CTRL_IDX      = 10'h270;
    localparam logic [9:0] PERIOD_B0_IDX     = 10'h271;
    localparam logic [9:0] PERIOD_B1_IDX     = 10'h272;
    localparam logic [9:0] PERIOD_B2_IDX     = 10'h273;
    localparam logic [9:0] RESULT_CTRL_IDX   = 10'h274;
    localparam logic [9:0] RESULT_B0_IDX     = 10'h275;
    localparam logic [9:0] RESULT_B1_IDX     = 10'h276;
    localparam logic [9:0] RESULT_B2_IDX     = 10'h277;
    localparam logic [9:0] PCOUNT_RESULT_IDX = 10'h278;
    localparam logic [9:0] SB_CTRL_IDX       = 10'h279;
    localparam logic [9:0] SB_SELECT_IDX     = 10'h27A;

    // field positions
    localparam int PEAK_EN_BIT    = 1;
    localparam int UPDATE_BIT     = 4;
    localparam int RESULT_SEL_BIT = 0;
    localparam int SB_EN_BIT      = 0;
    localparam int SB_PEAK_BIT    = 1;
    localparam int PEAK_LSB       = 7;

    // values after reset
    localparam logic [1:0]  SYNC_MODE_RESET  = 2'h0;
    localparam logic        PEAK_EN_RESET    = 1'h0;
    localparam logic [23:0] PERIOD_RESET     = 24'h000000;
    localparam logic        RESULT_SEL_RESET = 1'h1;
    localparam logic        SB_EN_RESET      = 1'h0;
    localparam logic        SB_PEAK_RESET    = 1'h0;

    // result selection codes
    localparam logic RESULT_SEL_PEAK = 1'h1;

    // synchronization modes; all but off are triggered by the reference strobe
    typedef enum logic [1:0] {
        SMP_SYNC_OFF     = 2'b00,
        SMP_SYNC_CONT    = 2'b01,
        SMP_SYNC_ONCE    = 2'b10,
        SMP_SYNC_ONCE_ALT = 2'b11
    } smp_sync_type;

    // ahb transfer type carrying a new transfer, and the okay response
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY    = 2'h0;
endpackage

// ===== smp_mon_if.sv
// carrier between the monitor control and its timer and detector
`timescale 1ns/10ps
interface smp_mon_if #(
    parameter int SAMPLE_W = 13,
    parameter int PERIOD_W = 24,
    parameter int PEAK_W   = 13
);
    logic                       enable;
    logic                       restart;
    logic                       sample_valid;
    logic signed [SAMPLE_W-1:0] sample;
    logic [PERIOD_W-1:0]        period;
    logic                       tick;
    logic [PEAK_W-1:0]          peak;

    modport ctrl (output enable, restart, sample_valid, sample, period,
                  input tick, peak);
    modport timer (input enable, restart, sample_valid, period,
                   output tick);
    modport detector (input enable, restart, sample_valid, sample, tick,
                      output peak);
endinterface

// ===== smp_period_timer.sv
// period counter in decimated output clock cycles
`timescale 1ns/10ps
module smp_period_timer #(
    parameter int PERIOD_W = 24
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // monitor carrier
    smp_mon_if.timer mon
);
    import smp_pkg::*;

    typedef struct packed {
        logic [PERIOD_W-1:0] count;
    } smp_timer_state_type;

    smp_timer_state_type state;
    smp_timer_state_type next_state;
    logic [PERIOD_W:0]   count_plus;
    logic                period_done;

    // a period of zero behaves as a period of one
    assign count_plus  = {1'b0, state.count} + {{PERIOD_W{1'b0}}, 1'b1};
    assign period_done = count_plus >= {1'b0, mon.period};
    assign mon.tick    = mon.enable & mon.sample_valid & ~mon.restart
                         & period_done;

    always_comb begin
        next_state = state;
        if (~mon.enable || mon.restart) begin
            next_state.count = '0;
        end else if (mon.sample_valid) begin
            if (period_done) begin
                next_state.count = '0;
            end else begin
                next_state.count = count_plus[PERIOD_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// ===== smp_peak_detector.sv
// running absolute peak tracker with end-of-period latch
`timescale 1ns/10ps
module smp_peak_detector #(
    parameter int SAMPLE_W = 13,
    parameter int PEAK_W   = 13
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // monitor carrier
    smp_mon_if.detector mon
);
    import smp_pkg::*;

    typedef struct packed {
        logic [PEAK_W-1:0] running;
        logic [PEAK_W-1:0] latched;
    } smp_peak_state_type;

    smp_peak_state_type  state;
    smp_peak_state_type  next_state;
    logic [SAMPLE_W-1:0] magnitude;
    logic [PEAK_W-1:0]   highest;

    // negation of the most negative code still fits unsigned
    assign magnitude = mon.sample[SAMPLE_W-1] ? SAMPLE_W'(-mon.sample)
                                              : SAMPLE_W'(mon.sample);
    assign highest   = (PEAK_W'(magnitude) > state.running)
                       ? PEAK_W'(magnitude) : state.running;
    assign mon.peak  = state.latched;

    always_comb begin
        next_state = state;
        if (~mon.enable || mon.restart) begin
            next_state.running = '0;
        end else if (mon.sample_valid) begin
            if (mon.tick) begin
                next_state.latched = highest;
                next_state.running = '0;
            end else begin
                next_state.running = highest;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

// ===== smp_signal_monitor.sv
// signal monitor with peak detector and ahb-lite register slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module smp_signal_monitor #(
    parameter int SAMPLE_W = 13,
    parameter int PERIOD_W = 24,
    parameter int PEAK_W   = 13
) (
    // clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // ahb-lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic [1:0]                      hresp,
    output logic [31:0]                     hrdata,
    // decimated samples and reference strobe
    input  wire logic                       sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] sample_data,
    input  wire logic                       system_reference_strobe,
    // side-band monitor port
    output logic                            sideband_monitor_valid,
    output logic [PEAK_W-1:0]               sideband_monitor_data
);
    import smp_pkg::*;

    typedef struct packed {
        logic                wr_pend;
        logic                rd_pend;
        logic [9:0]          idx;
        logic                ready;
        logic [31:0]         rdata;
        smp_sync_type        sync_mode;
        logic                once_armed;
        logic                peak_en;
        logic [23:0]         period;
        logic                result_sel;
        logic [19:0]         result;
        logic [7:0]          period_total;
        logic [7:0]          period_cnt_result;
        logic                sb_en;
        logic                sb_peak;
        logic                tick_seen;
        logic                sb_valid;
        logic [PEAK_W-1:0]   sb_data;
    } smp_state_type;

    smp_state_type state;
    smp_state_type next_state;

    smp_mon_if #(
        .SAMPLE_W (SAMPLE_W),
        .PERIOD_W (PERIOD_W),
        .PEAK_W   (PEAK_W)
    ) mon ();

    logic        take;
    logic        wr_hit;
    logic        restart;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic [19:0] fresh_result;
    logic        new_sel;

    smp_period_timer #(
        .PERIOD_W (PERIOD_W)
    ) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .mon     (mon.timer)
    );

    smp_peak_detector #(
        .SAMPLE_W (SAMPLE_W),
        .PEAK_W   (PEAK_W)
    ) u_peak (
        .hclk    (hclk),
        .hresetn (hresetn),
        .mon     (mon.detector)
    );

    // bus phase decode
    assign take  = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign wbyte = hwdata[7:0];
    assign wr_hit = state.wr_pend;

    // reference strobe gated by sync mode into restart, not resynchronised
    always_comb begin
        unique case (state.sync_mode)
            SMP_SYNC_OFF:      restart = 1'b0;
            SMP_SYNC_CONT:     restart = system_reference_strobe;
            SMP_SYNC_ONCE,
            SMP_SYNC_ONCE_ALT: restart = system_reference_strobe
                                         & state.once_armed;
        endcase
    end

    assign mon.enable       = state.peak_en;
    assign mon.restart      = restart;
    assign mon.sample_valid = sample_valid;
    assign mon.sample       = sample_data;
    assign mon.period       = PERIOD_W'(state.period);

    // a write in the same cycle picks the selection for the copy
    assign new_sel = (wr_hit && state.idx == RESULT_CTRL_IDX)
                     ? wbyte[RESULT_SEL_BIT] : state.result_sel;
    assign fresh_result = (new_sel == RESULT_SEL_PEAK)
                          ? {mon.peak, {PEAK_LSB{1'b0}}}
                          : 20'h00000;

    // read mux; unmapped indices read zero
    always_comb begin
        rbyte = 8'h00;
        unique case (state.idx)
            SYNC_CTRL_IDX:     rbyte = {6'h00, state.sync_mode};
            MON_CTRL_IDX:      rbyte = {6'h00, state.peak_en, 1'b0};
            PERIOD_B0_IDX:     rbyte = state.period[7:0];
            PERIOD_B1_IDX:     rbyte = state.period[15:8];
            PERIOD_B2_IDX:     rbyte = state.period[23:16];
            RESULT_CTRL_IDX:   rbyte = {7'h00, state.result_sel};
            RESULT_B0_IDX:     rbyte = state.result[7:0];
            RESULT_B1_IDX:     rbyte = state.result[15:8];
            RESULT_B2_IDX:     rbyte = {4'h0, state.result[19:16]};
            PCOUNT_RESULT_IDX: rbyte = state.period_cnt_result;
            SB_CTRL_IDX:       rbyte = {7'h00, state.sb_en};
            SB_SELECT_IDX:     rbyte = {6'h00, state.sb_peak, 1'b0};
            default:           rbyte = 8'h00;
        endcase
    end

    always_comb begin
        next_state = state;
        next_state.wr_pend = 1'b0;

        // read data phase: one wait cycle, then registered data
        if (state.rd_pend) begin
            next_state.rd_pend = 1'b0;
            next_state.rdata   = {24'h000000, rbyte};
            next_state.ready   = 1'b1;
        end

        // address phase capture
        if (take) begin
            next_state.idx     = haddr[11:2];
            next_state.wr_pend = hwrite;
            next_state.rd_pend = ~hwrite;
            next_state.ready   = hwrite;
        end

        // period end bookkeeping
        next_state.tick_seen = mon.tick;
        if (mon.tick) begin
            next_state.period_total = state.period_total + 8'h01;
        end

        // side-band output one cycle after the latch
        next_state.sb_valid = state.tick_seen & state.sb_en
                              & state.sb_peak;
        if (state.tick_seen && state.sb_en && state.sb_peak) begin
            next_state.sb_data = mon.peak;
        end

        // strobe use consumes the one-shot arm
        if (restart) begin
            next_state.once_armed = 1'b0;
        end

        // register writes in the data phase
        if (wr_hit) begin
            unique case (state.idx)
                SYNC_CTRL_IDX: begin
                    next_state.sync_mode  = smp_sync_type'(wbyte[1:0]);
                    next_state.once_armed = wbyte[1];
                end
                MON_CTRL_IDX: begin
                    next_state.peak_en = wbyte[PEAK_EN_BIT];
                end
                PERIOD_B0_IDX: begin
                    next_state.period[7:0] = wbyte;
                end
                PERIOD_B1_IDX: begin
                    next_state.period[15:8] = wbyte;
                end
                PERIOD_B2_IDX: begin
                    next_state.period[23:16] = wbyte;
                end
                RESULT_CTRL_IDX: begin
                    next_state.result_sel = wbyte[RESULT_SEL_BIT];
                    // update bit is never stored, so it reads back zero
                    if (wbyte[UPDATE_BIT]) begin
                        next_state.result = fresh_result;
                        next_state.period_cnt_result =
                            state.period_total;
                    end
                end
                SB_CTRL_IDX: begin
                    next_state.sb_en = wbyte[SB_EN_BIT];
                end
                SB_SELECT_IDX: begin
                    next_state.sb_peak = wbyte[SB_PEAK_BIT];
                end
                default: begin
                    next_state.sb_peak = state.sb_peak;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state                   <= '0;
            state.ready             <= 1'b1;
            state.sync_mode         <= smp_sync_type'(SYNC_MODE_RESET);
            state.peak_en           <= PEAK_EN_RESET;
            state.period            <= PERIOD_RESET;
            state.result_sel        <= RESULT_SEL_RESET;
            state.sb_en             <= SB_EN_RESET;
            state.sb_peak           <= SB_PEAK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // bus and side-band outputs from flip-flops, except hresp, which is tied to okay
    assign hreadyout              = state.ready;
    assign hresp                  = HRESP_OKAY;
    assign hrdata                 = state.rdata;
    assign sideband_monitor_valid = state.sb_valid;
    assign sideband_monitor_data  = state.sb_data;
endmodule

// ===== smp_signal_monitor_props.sv
// port assertions for the signal monitor
`timescale 1ns/10ps
module smp_signal_monitor_props
    import smp_pkg::*;
#(
    parameter int PEAK_W = 13
) (
    // clock and reset
    input wire logic              hclk,
    input wire logic              hresetn,
    // ahb-lite slave
    input wire logic              hsel,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic [1:0]        hresp,
    input wire logic [31:0]       hrdata,
    // samples and side-band
    input wire logic              sample_valid,
    input wire logic              sideband_monitor_valid,
    input wire logic [PEAK_W-1:0] sideband_monitor_data
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic                         rd_take;
    logic                         wr_take;
    assign rd_take = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    assign wr_take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;

    AST_READ_WAIT: assert property (rd_take
        |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_WRITE_NO_WAIT: assert property (wr_take |=> hreadyout)
        else $error("write stalled");
    AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
        else $error("wait longer than one cycle");
    AST_RDATA_HOLD: assert property ($changed(hrdata)
        |-> $rose(hreadyout))
        else $error("read data moved outside a read");
    AST_RDATA_BYTE: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_OKAY: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    AST_SB_DATA: assert property ($changed(sideband_monitor_data)
        |-> sideband_monitor_valid)
        else $error("side-band data moved without pulse");
    AST_SB_CAUSE: assert property (sideband_monitor_valid
        |-> $past(sample_valid, 2))
        else $error("side-band pulse without period end sample");

    cover property (rd_take);
    cover property (wr_take);
    cover property (sideband_monitor_valid);
endmodule
bind smp_signal_monitor smp_signal_monitor_props #(.PEAK_W(PEAK_W))
    u_smp_signal_monitor_props (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .sample_valid,
    .sideband_monitor_valid, .sideband_monitor_data);

// ===== smp_signal_monitor_tb_top.sv
// self-checking bench for the signal monitor peak detector
`timescale 1ns/10ps
module smp_signal_monitor_tb_top;
    import smp_pkg::*;
    logic               hclk = 1'b0;
    logic               hresetn = 1'b0;
    logic               hsel = 1'b0;
    logic [31:0]        haddr = 32'h0;
    logic [1:0]         htrans = 2'h0;
    logic               hwrite = 1'b0;
    logic [2:0]         hsize = 3'h2;
    logic [31:0]        hwdata = 32'h0;
    logic               hready;
    logic               hreadyout;
    logic [1:0]         hresp;
    logic [31:0]        hrdata;
    logic               sample_valid = 1'b0;
    logic signed [12:0] sample_data = 13'h0;
    logic               strobe = 1'b0;
    logic               sb_valid;
    logic [12:0]        sb_data;
    logic [12:0]        sbq[$];
    int                 bad_count = 0;
    int                 samples_checked = 0;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) begin
        if (sb_valid === 1'b1) begin
            sbq.push_back(sb_data);
        end
    end

    smp_signal_monitor u_smp_signal_monitor (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sample_valid(sample_valid),
        .sample_data(sample_data), .system_reference_strobe(strobe),
        .sideband_monitor_valid(sb_valid), .sideband_monitor_data(sb_data)
    );

    task automatic stop_test();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // bounded wait for ready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            $display("[FAIL] hready expected 1 seen %b", hreadyout);
            stop_test();
        end
    endtask

    task automatic bus(input logic w, input logic [9:0] idx,
                       input logic [7:0] wd, output logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr  <= {20'h00000, idx, 2'h0};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        wait_ready();
        d = hrdata;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
        chk("hresp", 32'h0, {30'h0, hresp});
    endtask

    task automatic rd(input string nm, input logic [9:0] idx,
                      input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk(nm, {24'h000000, exp}, d);
    endtask

    task automatic feed(input logic signed [12:0] s);
        @(posedge hclk);
        sample_valid <= 1'b1;
        sample_data  <= s;
        @(posedge hclk);
        sample_valid <= 1'b0;
    endtask

    task automatic t_reset();
        logic [9:0] ix[12] = '{SYNC_CTRL_IDX, MON_CTRL_IDX, PERIOD_B0_IDX,
            PERIOD_B1_IDX, PERIOD_B2_IDX, RESULT_CTRL_IDX, RESULT_B0_IDX,
            RESULT_B1_IDX, RESULT_B2_IDX, PCOUNT_RESULT_IDX, SB_CTRL_IDX,
            SB_SELECT_IDX};
        for (int i = 0; i < 12; i++) begin
            rd("reset", ix[i], ix[i] == RESULT_CTRL_IDX);
        end
        rd("unmapped", 10'h280, 8'h00);
    endtask

    task automatic t_access();
        wr(SYNC_CTRL_IDX, 8'h03);
        rd("sync mode", SYNC_CTRL_IDX, 8'h03);
        wr(SYNC_CTRL_IDX, 8'h00);
        wr(PERIOD_B1_IDX, 8'hA5);
        wr(PERIOD_B2_IDX, 8'h5A);
        rd("period b1", PERIOD_B1_IDX, 8'hA5);
        rd("period b2", PERIOD_B2_IDX, 8'h5A);
        wr(PERIOD_B1_IDX, 8'h00);
        wr(PERIOD_B2_IDX, 8'h00);
        wr(PERIOD_B0_IDX, 8'h04);
        rd("period b0", PERIOD_B0_IDX, 8'h04);
        wr(RESULT_B0_IDX, 8'hFF);
        rd("result ro", RESULT_B0_IDX, 8'h00);
        wr(RESULT_CTRL_IDX, 8'h11);
        rd("update clears", RESULT_CTRL_IDX, 8'h01);
        wr(SB_CTRL_IDX, 8'h01);
        wr(SB_SELECT_IDX, 8'h02);
        rd("sb enable", SB_CTRL_IDX, 8'h01);
        rd("sb select", SB_SELECT_IDX, 8'h02);
        wr(MON_CTRL_IDX, 8'h02);
        rd("enable", MON_CTRL_IDX, 8'h02);
    endtask

    // one period of four samples, checked on side-band and results
    task automatic t_period(input logic signed [12:0] s[4],
                            input logic [7:0] b1, input logic [7:0] cnt);
        sbq.delete();
        for (int i = 0; i < 4; i++) begin
            feed(s[i]);
        end
        repeat (4) @(posedge hclk);
        chk("sb count", 32'h1, sbq.size());
        chk("sb peak", {24'h0, b1}, {19'h0, sbq[0]});
        rd("before update", RESULT_B1_IDX,
           cnt == 8'h01 ? 8'h00 : 8'h04);
        wr(RESULT_CTRL_IDX, 8'h11);
        rd("result b0", RESULT_B0_IDX, 8'h80);
        rd("result b1", RESULT_B1_IDX, b1[7:0] >> 1);
        rd("result b2", RESULT_B2_IDX, 8'h00);
        rd("period count", PCOUNT_RESULT_IDX, cnt);
    endtask

    task automatic t_disable();
        wr(MON_CTRL_IDX, 8'h00);
        sbq.delete();
        repeat (4) feed(13'sd100);
        chk("sb idle", 32'h0, sbq.size());
        wr(RESULT_CTRL_IDX, 8'h10);
        rd("reserved sel", RESULT_B1_IDX, 8'h00);
        rd("count kept", PCOUNT_RESULT_IDX, 8'h02);
        wr(RESULT_CTRL_IDX, 8'h11);
        rd("peak kept", RESULT_B1_IDX, 8'h01);
    endtask

    task automatic t_sync(input logic [7:0] mode, input logic [31:0] exp);
        wr(MON_CTRL_IDX, 8'h00);
        wr(SYNC_CTRL_IDX, mode);
        wr(MON_CTRL_IDX, 8'h02);
        sbq.delete();
        feed(13'sd7);
        @(posedge hclk);
        strobe <= 1'b1;
        @(posedge hclk);
        strobe <= 1'b0;
        repeat (3) feed(-13'sd2);
        feed(13'sd3);
        repeat (4) @(posedge hclk);
        chk("sync peak", exp, sbq.size() ? {19'h0, sbq[0]} : '1);
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_access();
        t_period('{13'sd5, -13'sd9, 13'sd3, 13'sd2}, 8'h09, 8'h01);
        t_period('{13'sd1, -13'sd3, 13'sd2, 13'sd1}, 8'h03, 8'h02);
        t_disable();
        for (int m = 0; m < 4; m++) begin
            t_sync(m, m == 0 ? 32'h7 : 32'h3);
        end
        stop_test();
    end
endmodule
